// *** logic/fpl_pkg.sv ***
// Operation
// RQ1: open sequences per exchange sits in bits 23-16 of class word 3.
// RQ2: recipient keeps open-sequence limit plus two sequence status entries per exchange.
// RQ3: vendor version field counts only when common word 1 bit 29 is one.
// RQ4: vendor field is 2-byte code, 6 bytes of levels, 8 reserved bytes.
// RQ5: common parameters, then port name, then fabric name follow the command code.
// RQ6: then class 1, 2, 3 groups, then two reserved 16-byte groups; the code sends one reserved 16-byte group, then the vendor field.
// RQ7: word 0 bits 31-24 highest version, bits 23-16 lowest version.
// RQ8: version code 00 none, 06 to 09 levels, all else reserved.
// RQ9: port supports every version from lowest to highest advertised.
// RQ10: overlapping ranges run at the highest mutually supported version.
// RQ11: word 0 bits 15-0 hold one credit pool for all classes.
// RQ12: credit bit 15 zero, zero reserved, 1 to 32767 buffers.
// RQ13: word 1 bit 28 is the port type and is always one here.
// RQ14: word 1 bits 15-0 give largest receivable data field size.
// RQ15: receive size below 128 or above 2112 or not multiple of four invalid.
// RQ16: at least 128 bytes accepted, 256 recommended.
// RQ17: error-detect timeout in word 3 counts 1 ms units.
// RQ18: resource-allocation timeout in word 2 counts 1 ms units.
// RQ19: port name unique in fabric domain, bits 63-60 pick format.
// RQ20: fabric name unique per fabric, bits 63-60 pick format.
// RQ21: class word 0 bit 31 marks class supported, else group ignored.
// RQ22: receiving node port flags bad size or port-type bit as erroneous.
package fpl_pkg;
    // register byte offsets
    localparam logic [7:0] FPL_CTRL_OFS    = 8'h00;
    localparam logic [7:0] FPL_STAT_OFS    = 8'h04;
    localparam logic [7:0] FPL_VER_OFS     = 8'h08;
    localparam logic [7:0] FPL_CREDIT_OFS  = 8'h0C;
    localparam logic [7:0] FPL_RXSIZE_OFS  = 8'h10;
    localparam logic [7:0] FPL_RATOV_OFS   = 8'h14;
    localparam logic [7:0] FPL_EDTOV_OFS   = 8'h18;
    localparam logic [7:0] FPL_PNAME_LO    = 8'h1C;
    localparam logic [7:0] FPL_PNAME_HI    = 8'h20;
    localparam logic [7:0] FPL_FNAME_LO    = 8'h24;
    localparam logic [7:0] FPL_FNAME_HI    = 8'h28;
    localparam logic [7:0] FPL_CLS_OFS     = 8'h2C;
    localparam logic [7:0] FPL_OSPE_OFS    = 8'h30;
    localparam logic [7:0] FPL_PEER_OFS    = 8'h34;
    localparam logic [7:0] FPL_VCODE_OFS   = 8'h38;
    localparam logic [7:0] FPL_VLVL_HI     = 8'h3C;
    localparam logic [7:0] FPL_VLVL_LO     = 8'h40;
    // field positions
    localparam int FPL_CTRL_START_BIT = 0;
    localparam int FPL_CTRL_VEND_BIT  = 1;
    localparam int FPL_W1_VEND_BIT    = 29;
    localparam int FPL_W1_TYPE_BIT    = 28;
    localparam int FPL_CLS_VALID_BIT  = 31;
    // version codes, size limits and the extra status entries
    localparam logic [7:0]  FPL_VER_FIRST = 8'h06;
    localparam logic [7:0]  FPL_VER_LAST  = 8'h09;
    localparam logic [15:0] FPL_RX_MIN    = 16'h0080;
    localparam logic [15:0] FPL_RX_MAX    = 16'h0840;
    localparam logic [8:0]  FPL_SSB_EXTRA = 9'h002;
    // payload layout in words after the command code
    localparam logic [4:0]  FPL_W_PNAME   = 5'h04;
    localparam logic [4:0]  FPL_W_CLASS   = 5'h08;
    localparam logic [4:0]  FPL_W_RSVD    = 5'h14;
    localparam logic [4:0]  FPL_W_VEND    = 5'h18;
    localparam logic [4:0]  FPL_W_LAST    = 5'h1B;
    // reset values and bus response codes
    localparam logic [15:0] FPL_VER_RST    = 16'h0906;
    localparam logic [15:0] FPL_CREDIT_RST = 16'h0001;
    localparam logic [15:0] FPL_RXSIZE_RST = 16'h0100;
    localparam logic [31:0] FPL_RATOV_RST  = 32'h0000_2710;
    localparam logic [31:0] FPL_EDTOV_RST  = 32'h0000_07D0;
    localparam logic [1:0]  FPL_OKAY       = 2'h0;
    localparam logic [1:0]  FPL_SLVERR     = 2'h2;

    typedef struct packed {
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        vend_en;
        logic [15:0] ver;
        logic [15:0] credit;
        logic [15:0] rxsize;
        logic [31:0] ratov;
        logic [31:0] edtov;
        logic [63:0] pname;
        logic [63:0] fname;
        logic [2:0]  cls_en;
        logic [7:0]  ospe;
        logic [15:0] peer_ver;
        logic [15:0] vcode;
        logic [47:0] vlvl;
        logic        cfg_ok;
        logic        overlap;
        logic [7:0]  oper_ver;
        logic [8:0]  ssb_cnt;
        logic        busy;
        logic [4:0]  idx;
        logic        tx_valid;
        logic [31:0] tx_data;
        logic        tx_last;
    } fpl_state_t;
endpackage : fpl_pkg

// *** logic/fpl_params.sv ***
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fpl_params (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             tx_valid,
    output logic [31:0]      tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    output logic [8:0]       ssb_entries,
    output logic [7:0]       oper_version
);
    import fpl_pkg::*;

    fpl_state_t st_r;
    fpl_state_t st_nxt;

    // byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic ver_known(input logic [7:0] v);
        return (v >= FPL_VER_FIRST) && (v <= FPL_VER_LAST); // [RQ8]
    endfunction : ver_known

    // one payload word by index; idle groups go out as zero
    function automatic logic [31:0] word_at(input fpl_state_t s, input logic [4:0] i);
        logic [4:0]  rel;
        logic [1:0]  grp;
        logic [31:0] w;
        rel = i - FPL_W_CLASS;
        grp = rel[3:2];
        w   = 32'h0000_0000;
        if (i < FPL_W_PNAME) begin
            unique case (i[1:0])
                2'h0: w = {s.ver, s.credit};                      // [RQ7] [RQ11]
                2'h1: w = {2'h0, s.vend_en, 1'b1, 12'h000, s.rxsize}; // [RQ13] [RQ3] [RQ14]
                2'h2: w = s.ratov;                                // [RQ18]
                2'h3: w = s.edtov;                                // [RQ17]
            endcase
        end else if (i < FPL_W_CLASS) begin
            // names go out most significant word first, format nibble leading
            unique case (i[1:0])
                2'h0: w = s.pname[63:32];                         // [RQ19] [RQ5]
                2'h1: w = s.pname[31:0];
                2'h2: w = s.fname[63:32];                         // [RQ20]
                2'h3: w = s.fname[31:0];
            endcase
        end else if (i < FPL_W_RSVD) begin
            // a class left off sends an all-zero group, which the far end ignores
            if (s.cls_en[grp]) begin                              // [RQ6] [RQ21]
                if (rel[1:0] == 2'h0) begin
                    w[FPL_CLS_VALID_BIT] = 1'b1;
                end else if (rel[1:0] == 2'h3) begin
                    w[23:16] = s.ospe;                            // [RQ1]
                end
            end
        end else if (i >= FPL_W_VEND && s.vend_en) begin
            // code, six level bytes, then eight vendor bytes kept zero
            if (i == FPL_W_VEND) begin
                w = {s.vcode, s.vlvl[47:32]};                     // [RQ4]
            end else if (i == FPL_W_VEND + 5'h01) begin
                w = s.vlvl[31:0];
            end
        end
        return w;
    endfunction : word_at

    // next-state: bus slave, checks and payload sequencer
    always_comb begin
        logic [7:0]  lo_max;
        logic [7:0]  hi_min;
        logic [31:0] rd;
        logic        hit;
        st_nxt = st_r;
        lo_max = 8'h00;
        hi_min = 8'h00;
        rd     = 32'h0000_0000;
        hit    = 1'b1;
        // configuration sanity, refreshed every cycle
        st_nxt.cfg_ok = ver_known(st_r.ver[15:8]) && ver_known(st_r.ver[7:0])
                     && (st_r.ver[15:8] >= st_r.ver[7:0])                       // [RQ9]
                     && !st_r.credit[15] && (st_r.credit != 16'h0000)            // [RQ12]
                     && (st_r.rxsize >= FPL_RX_MIN) && (st_r.rxsize <= FPL_RX_MAX)
                     && (st_r.rxsize[1:0] == 2'h0);                              // [RQ15] [RQ16]
        // version negotiation against the peer's advertised range
        lo_max = (st_r.ver[7:0] > st_r.peer_ver[7:0]) ? st_r.ver[7:0] : st_r.peer_ver[7:0];
        hi_min = (st_r.ver[15:8] < st_r.peer_ver[15:8]) ? st_r.ver[15:8] : st_r.peer_ver[15:8];
        st_nxt.overlap  = ver_known(lo_max) && ver_known(hi_min) && (lo_max <= hi_min);
        st_nxt.oper_ver = st_nxt.overlap ? hi_min : 8'h00;                       // [RQ10]
        st_nxt.ssb_cnt  = {1'b0, st_r.ospe} + FPL_SSB_EXTRA;                     // [RQ2]

        // write address and data are caught in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = FPL_OKAY;
            unique case (st_r.aw_addr)
                FPL_CTRL_OFS: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.vend_en = st_r.w_data[FPL_CTRL_VEND_BIT];
                        // start is refused while busy or while the setup is unusable
                        if (st_r.w_data[FPL_CTRL_START_BIT] && !st_r.busy && st_r.cfg_ok) begin
                            st_nxt.busy     = 1'b1;
                            st_nxt.idx      = 5'h00;
                            st_nxt.tx_valid = 1'b1;
                            st_nxt.tx_data  = word_at(st_r, 5'h00);
                            st_nxt.tx_last  = 1'b0;
                        end
                    end
                end
                FPL_STAT_OFS:   ;
                FPL_VER_OFS:    st_nxt.ver      = 16'(merge({16'h0000, st_r.ver}, st_r.w_data, st_r.w_strb));
                FPL_CREDIT_OFS: st_nxt.credit   = 16'(merge({16'h0000, st_r.credit}, st_r.w_data, st_r.w_strb));
                FPL_RXSIZE_OFS: st_nxt.rxsize   = 16'(merge({16'h0000, st_r.rxsize}, st_r.w_data, st_r.w_strb));
                FPL_RATOV_OFS:  st_nxt.ratov    = merge(st_r.ratov, st_r.w_data, st_r.w_strb);
                FPL_EDTOV_OFS:  st_nxt.edtov    = merge(st_r.edtov, st_r.w_data, st_r.w_strb);
                FPL_PNAME_LO:   st_nxt.pname[31:0]  = merge(st_r.pname[31:0], st_r.w_data, st_r.w_strb);
                FPL_PNAME_HI:   st_nxt.pname[63:32] = merge(st_r.pname[63:32], st_r.w_data, st_r.w_strb);
                FPL_FNAME_LO:   st_nxt.fname[31:0]  = merge(st_r.fname[31:0], st_r.w_data, st_r.w_strb);
                FPL_FNAME_HI:   st_nxt.fname[63:32] = merge(st_r.fname[63:32], st_r.w_data, st_r.w_strb);
                FPL_CLS_OFS:    st_nxt.cls_en   = 3'(merge({29'h0, st_r.cls_en}, st_r.w_data, st_r.w_strb));
                FPL_OSPE_OFS:   st_nxt.ospe     = 8'(merge({24'h0, st_r.ospe}, st_r.w_data, st_r.w_strb));
                FPL_PEER_OFS:   st_nxt.peer_ver = 16'(merge({16'h0000, st_r.peer_ver}, st_r.w_data, st_r.w_strb));
                FPL_VCODE_OFS:  st_nxt.vcode    = 16'(merge({16'h0000, st_r.vcode}, st_r.w_data, st_r.w_strb));
                FPL_VLVL_HI:    st_nxt.vlvl[47:32] = 16'(merge({16'h0000, st_r.vlvl[47:32]}, st_r.w_data, st_r.w_strb));
                FPL_VLVL_LO:    st_nxt.vlvl[31:0]  = merge(st_r.vlvl[31:0], st_r.w_data, st_r.w_strb);
                default:        st_nxt.bresp    = FPL_SLVERR;
            endcase
        end
        st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;

        // read path: one word per request, answered on the following edge
        unique case (s_axi_araddr)
            FPL_CTRL_OFS:   rd = {30'h0, st_r.vend_en, 1'b0};
            FPL_STAT_OFS:   rd = {7'h00, st_r.ssb_cnt, st_r.oper_ver, 5'h00, st_r.overlap, st_r.cfg_ok, st_r.busy};
            FPL_VER_OFS:    rd = {16'h0000, st_r.ver};
            FPL_CREDIT_OFS: rd = {16'h0000, st_r.credit};
            FPL_RXSIZE_OFS: rd = {16'h0000, st_r.rxsize};
            FPL_RATOV_OFS:  rd = st_r.ratov;
            FPL_EDTOV_OFS:  rd = st_r.edtov;
            FPL_PNAME_LO:   rd = st_r.pname[31:0];
            FPL_PNAME_HI:   rd = st_r.pname[63:32];
            FPL_FNAME_LO:   rd = st_r.fname[31:0];
            FPL_FNAME_HI:   rd = st_r.fname[63:32];
            FPL_CLS_OFS:    rd = {29'h0, st_r.cls_en};
            FPL_OSPE_OFS:   rd = {24'h0, st_r.ospe};
            FPL_PEER_OFS:   rd = {16'h0000, st_r.peer_ver};
            FPL_VCODE_OFS:  rd = {16'h0000, st_r.vcode};
            FPL_VLVL_HI:    rd = {16'h0000, st_r.vlvl[47:32]};
            FPL_VLVL_LO:    rd = st_r.vlvl[31:0];
            default:        hit = 1'b0;
        endcase
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd;
            st_nxt.rresp  = hit ? FPL_OKAY : FPL_SLVERR;
        end
        st_nxt.arready = !st_nxt.rvalid;

        // payload sequencer, held by tx_ready
        if (st_r.tx_valid && tx_ready) begin
            if (st_r.tx_last) begin
                st_nxt.busy     = 1'b0;
                st_nxt.tx_valid = 1'b0;
                st_nxt.tx_last  = 1'b0;
            end else begin
                st_nxt.idx     = st_r.idx + 5'h01;
                st_nxt.tx_data = word_at(st_r, st_r.idx + 5'h01);
                st_nxt.tx_last = (st_r.idx + 5'h01) == FPL_W_LAST;
            end
        end
    end

    // the whole state in one register, frozen while ce is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r          <= '0;
            st_r.ver      <= FPL_VER_RST;
            st_r.credit   <= FPL_CREDIT_RST;
            st_r.rxsize   <= FPL_RXSIZE_RST;
            st_r.ratov    <= FPL_RATOV_RST;
            st_r.edtov    <= FPL_EDTOV_RST;
            st_r.ssb_cnt  <= FPL_SSB_EXTRA;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign tx_valid      = st_r.tx_valid;
    assign tx_data       = st_r.tx_data;
    assign tx_last       = st_r.tx_last;
    assign ssb_entries   = st_r.ssb_cnt;
    assign oper_version  = st_r.oper_ver;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_beat(logic [4:0] n);
        st_r.tx_valid && st_r.idx == n;
    endsequence
    sequence s_final;
        ce && st_r.tx_valid && tx_ready && st_r.tx_last;
    endsequence

    property p_port_type;
        s_beat(5'h01) |-> tx_data[FPL_W1_TYPE_BIT] && (tx_data[FPL_W1_VEND_BIT] == st_r.vend_en);
    endproperty
    a_port_type: assert property (p_port_type) else $error("port type bit not one"); // [RQ13]
    property p_vend_off;
        s_beat(FPL_W_VEND) && !st_r.vend_en |-> tx_data == 32'h0000_0000;
    endproperty
    a_vend_off: assert property (p_vend_off) else $error("vendor field sent while disabled"); // [RQ3]
    property p_ospe;
        s_beat(5'h0B) |-> tx_data[23:16] == (st_r.cls_en[0] ? st_r.ospe : 8'h00);
    endproperty
    a_ospe: assert property (p_ospe) else $error("open sequence field misplaced"); // [RQ1]
    property p_cls2_off;
        s_beat(5'h0C) && !st_r.cls_en[1] |-> tx_data == 32'h0000_0000;
    endproperty
    a_cls2_off: assert property (p_cls2_off) else $error("disabled class group not zero"); // [RQ21]
    property p_start_ok;
        ce && !st_r.busy ##1 st_r.busy |-> $past(st_r.cfg_ok);
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("payload started with bad setup"); // [RQ15]
    property p_oper;
        // the result lags the ranges by one edge, so compare with last cycle's ranges
        st_r.overlap |-> st_r.oper_ver <= $past(st_r.ver[15:8]) && st_r.oper_ver <= $past(st_r.peer_ver[15:8])
                      && st_r.oper_ver >= $past(st_r.ver[7:0]);
    endproperty
    a_oper: assert property (p_oper) else $error("operating version outside ranges"); // [RQ10]
    property p_ssb;
        ce ##1 ce |-> st_r.ssb_cnt == {1'b0, $past(st_r.ospe)} + FPL_SSB_EXTRA;
    endproperty
    a_ssb: assert property (p_ssb) else $error("status entry count not limit plus two"); // [RQ2]
    property p_end;
        s_final |=> !st_r.busy && !tx_valid;
    endproperty
    a_end: assert property (p_end) else $error("payload did not end after last word"); // [RQ6]
    property p_hold;
        ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("payload word dropped under stall"); // [RQ5]
endmodule : fpl_params
`default_nettype wire

// *** dv/fpl_sink.sv ***
`timescale 1ns/1ns
`default_nettype none
// node port side of the login stream; it stores each payload and checks the fields it depends on
module fpl_sink (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_data,
    input  wire logic        tx_last,
    output logic             tx_ready,
    output logic [3:0]       nfr,
    output logic             lbad,
    output logic             err
);
    logic [31:0] words [0:27];
    logic [4:0]  cnt;
    logic [1:0]  ph;
    // ready drops one cycle in four, so the source has to hold its word through a stall
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph       <= 2'h0;
            tx_ready <= 1'b0;
            cnt      <= 5'h00;
            nfr      <= 4'h0;
            lbad     <= 1'b0;
            err      <= 1'b0;
        end else begin
            ph       <= ph + 2'h1;
            tx_ready <= (ph != 2'h2);
            if (tx_valid && tx_ready) begin
                words[cnt] <= tx_data;
                cnt        <= tx_last ? 5'h00 : cnt + 5'h01;
                nfr        <= nfr + {3'h0, tx_last};
                lbad       <= lbad | (tx_last != (cnt == 5'h1B)); // last flag only on word 27
                // a wrong port type or an unusable receive size marks the payload erroneous
                if (cnt == 5'h01)
                    err <= err | !tx_data[28] | (tx_data[15:0] < 16'h0080)
                               | (tx_data[15:0] > 16'h0840) | (|tx_data[1:0]);
            end
        end
    end
endmodule : fpl_sink
`default_nettype wire

// *** dv/fabric_port_login_params_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module fabric_port_login_params_tb_top;
    import fpl_pkg::*;
    logic        clk, rst_b, ce, tx_valid, tx_last, tx_ready, lbad, err, vend;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, oper_version;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q, tx_data;
    logic [3:0]  s_axi_wstrb, nfr;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
    logic [8:0]  ssb_entries;
    int          n_fail, check_count;
    // shadow of what software programs, used to predict the payload
    logic [15:0] ver = 16'h0906, cred = 16'h7FFF, rx = 16'h0840, vcode = 16'hA5C3;
    logic [31:0] ratov = 32'h0000_000A, edtov = 32'h0000_0014;
    logic [63:0] pn = 64'h2000_00A0_B8C1_D2E3, fn = 64'h1000_0051_2345_6789;
    logic [47:0] vlvl = 48'h1234_89AB_CDEF;
    logic [2:0]  cls = 3'h5;
    logic [7:0]  ospe = 8'h0F;
    // register tables: reset readback, config sweep, version pairs, payload setup
    logic [7:0]  ra [0:5] = '{FPL_STAT_OFS, FPL_VER_OFS, FPL_CREDIT_OFS, FPL_RXSIZE_OFS, FPL_RATOV_OFS, FPL_EDTOV_OFS};
    logic [31:0] rv [0:5] = '{32'h0002_0002, {16'h0, FPL_VER_RST}, {16'h0, FPL_CREDIT_RST}, {16'h0, FPL_RXSIZE_RST},
                              FPL_RATOV_RST, FPL_EDTOV_RST};
    logic [7:0]  ca [0:11] = '{FPL_RXSIZE_OFS, FPL_RXSIZE_OFS, FPL_RXSIZE_OFS, FPL_RXSIZE_OFS, FPL_CREDIT_OFS,
                               FPL_CREDIT_OFS, FPL_CREDIT_OFS, FPL_VER_OFS, FPL_VER_OFS, FPL_VER_OFS, FPL_VER_OFS, FPL_VER_OFS};
    logic [15:0] cv [0:11] = '{16'h0844, 16'h007C, 16'h0080, 16'h0840, 16'h0000, 16'h8000, 16'h7FFF,
                               16'h0A06, 16'h0609, 16'h0605, 16'h0900, 16'h0906};
    logic [11:0] cok = 12'h84C;
    logic [15:0] no [0:2] = '{16'h0707, 16'h0606, 16'h0906};
    logic [15:0] np [0:2] = '{16'h0906, 16'h0907, 16'h0806};
    logic [7:0]  nx [0:2] = '{8'h07, 8'h00, 8'h08};
    logic [7:0]  wa [0:10] = '{FPL_PNAME_LO, FPL_PNAME_HI, FPL_FNAME_LO, FPL_FNAME_HI, FPL_CLS_OFS, FPL_OSPE_OFS,
                               FPL_VCODE_OFS, FPL_VLVL_HI, FPL_VLVL_LO, FPL_RATOV_OFS, FPL_EDTOV_OFS};
    logic [31:0] wd [0:10] = '{32'hB8C1_D2E3, 32'h2000_00A0, 32'h2345_6789, 32'h1000_0051, 32'h5, 32'h0F,
                               32'hA5C3, 32'h1234, 32'h89AB_CDEF, 32'h0000_000A, 32'h0000_0014};

    fpl_params uut (.clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_valid, .tx_data, .tx_last,
        .tx_ready, .ssb_entries, .oper_version);
    fpl_sink sink (.clk, .rst_b, .tx_valid, .tx_data, .tx_last, .tx_ready, .nfr, .lbad, .err);

    task automatic close_out;
        begin
            if (n_fail == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count++;
            if (got !== exp) begin
                n_fail++;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask : chk

    // address and data go out together; each is dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_wdata  <= d;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            do begin
                @(posedge clk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid);
            bresp_q = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        begin
            @(posedge clk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            do begin
                @(posedge clk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid);
            {rd_q, rresp_q} = {s_axi_rdata, s_axi_rresp};
            s_axi_rready <= 1'b0;
        end
    endtask : rd

    function automatic logic [31:0] expw(input int i);
        logic [31:0] w;
        begin
            w = 32'h0000_0000;
            case (i)
                0: w = {ver, cred};
                1: w = {2'h0, vend, 1'b1, 12'h000, rx};
                2: w = ratov;
                3: w = edtov;
                4: w = pn[63:32];
                5: w = pn[31:0];
                6: w = fn[63:32];
                7: w = fn[31:0];
                24: w = vend ? {vcode, vlvl[47:32]} : 32'h0000_0000;
                25: w = vend ? vlvl[31:0] : 32'h0000_0000;
                default: begin
                    if (i >= 8 && i < 20 && cls[(i - 8) / 4] && i % 4 == 0)
                        w = 32'h8000_0000;
                    if (i >= 8 && i < 20 && cls[(i - 8) / 4] && i % 4 == 3)
                        w = {8'h00, ospe, 16'h0000};
                end
            endcase
            return w;
        end
    endfunction : expw

    // start a payload, try a second start while it runs, then compare every word
    task automatic frame(input logic [31:0] c, input logic [3:0] n);
        begin
            vend = c[1];
            wr(FPL_CTRL_OFS, c);
            wr(FPL_CTRL_OFS, c);
            while (nfr != n)
                @(posedge clk);
            for (int i = 0; i < 28; i++)
                chk(sink.words[i], expw(i));
            chk({30'h0, lbad, err}, 32'h0);
        end
    endtask : frame

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // a hang is cut short well after the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end

    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk({23'h0, ssb_entries}, 32'h2);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            chk(rd_q, rv[i]);
        end
        wr(8'h44, 32'hFFFF_FFFF);
        chk({30'h0, bresp_q}, {30'h0, FPL_SLVERR});
        rd(8'h44);
        chk({30'h0, rresp_q}, {30'h0, FPL_SLVERR});
        wr(FPL_RXSIZE_OFS, 32'h0000_0082);
        wr(FPL_CTRL_OFS, 32'h1);
        rd(FPL_STAT_OFS);
        chk({26'h0, nfr, rd_q[1:0]}, 32'h0);
        for (int i = 0; i < 12; i++) begin
            wr(ca[i], {16'h0, cv[i]});
            rd(FPL_STAT_OFS);
            chk({31'h0, rd_q[1]}, {31'h0, cok[i]});
        end
        for (int i = 0; i < 3; i++) begin
            wr(FPL_VER_OFS, {16'h0, no[i]});
            wr(FPL_PEER_OFS, {16'h0, np[i]});
            rd(FPL_STAT_OFS);
            chk({16'h0, oper_version, rd_q[15:8]}, {16'h0, nx[i], nx[i]});
        end
        for (int i = 0; i < 11; i++)
            wr(wa[i], wd[i]);
        frame(32'h3, 4'h1);
        chk({23'h0, ssb_entries}, 32'h11);
        cls = 3'h2;
        ospe = 8'hFF;
        wr(FPL_CLS_OFS, 32'h2);
        wr(FPL_OSPE_OFS, 32'hFF);
        frame(32'h1, 4'h2);
        chk({23'h0, ssb_entries}, 32'h101);
        repeat (64) @(posedge clk);
        chk({28'h0, nfr}, 32'h2);
        close_out();
    end
endmodule : fabric_port_login_params_tb_top
`default_nettype wire
